// ### rtl/loop_supervisor_pkg.sv
/*
 * constants, types and carriers shared by the process loop supervisor.
 * assumes a 200 MHz core clock; frequencies in 0.1 Hz, percents in 0.1 %.
 */
package loop_supervisor_pkg;
    // ------------------------------------------------------------
    // setting codes
    // ------------------------------------------------------------
    localparam logic [15:0] SETTING_OFF = 16'h270f;
    localparam logic [7:0] FN_INVERT = 8'h64;
    localparam logic [7:0] FN_LOOP = 8'h2f;
    localparam logic [7:0] FN_LOOP_N = 8'h93;
    localparam logic [7:0] FN_SUSPEND = 8'h46;
    localparam logic [7:0] FN_SUSPEND_N = 8'haa;
    localparam logic [7:0] ACT_REVERSE = 8'h14;
    localparam logic [7:0] ACT_FORWARD = 8'h15;
    localparam logic [7:0] MON_SET_POINT = 8'h34;
    localparam logic [7:0] MON_MEASURED = 8'h35;
    localparam logic [7:0] MON_DEVIATION = 8'h36;
    localparam logic [3:0] MODE_SWITCHOVER = 4'h6;
    // ------------------------------------------------------------
    // scaling and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SWITCH_MAX = 16'h0fa0;
    localparam logic [17:0] DEV_ZERO = 18'h003e8;
    localparam logic [17:0] CANCEL_ZERO = 18'h02710;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 200000;
    localparam int TIME_TICK_MS = 100;
    localparam int TIME_TICK_CYCLES = TIME_TICK_MS * CLK_KHZ;
    localparam int MON_PERIOD_MS = 10;
    localparam int MON_CYCLES = MON_PERIOD_MS * CLK_KHZ;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic loop_enable_input;
        logic preset_speed_high;
        logic preset_speed_mid;
        logic preset_speed_low;
        logic preset_speed_extra;
        logic jog;
    } pin_s;
    typedef struct packed {
        logic loop_active_flag;
        logic suspend;
    } status_s;
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_OPEN = 4'b0010,
        PH_LOOP = 4'b0100,
        PH_SLEEP = 4'b1000
    } phase_e;
endpackage

// ### rtl/hold_timer.sv
/*
 * counts how long a condition holds, in base ticks of a free prescaler.
 * assumes cond and limit come from logic on core_clk.
 */
module hold_timer
    import loop_supervisor_pkg::*;
#(
    parameter int TICK_CYCLES = TIME_TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // condition and limit in ticks
    input wire logic cond,
    input wire logic [15:0] limit,
    output logic expired
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    typedef struct packed {
        logic [PW-1:0] pre;
        logic [15:0] count;
        logic expired;
    } timer_s;
    timer_s s;
    timer_s next_s;
    logic tick;

    always_comb begin
        next_s = s;
        tick = (s.pre == PW'(TICK_CYCLES - 1));
        next_s.pre = tick ? '0 : s.pre + 1'b1;
        if (!cond) begin
            next_s.count = '0;
        end else if (tick && s.count != 16'hffff) begin
            next_s.count = s.count + 16'h0001;
        end
        next_s.expired = cond && (next_s.count > limit);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expired = s.expired;

    property p_restart;
        @(posedge core_clk) disable iff (!rstn)
        !cond |=> (s.count == 16'h0000) && !expired;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

    property p_needs_count;
        @(posedge core_clk) disable iff (!rstn)
        $rose(expired) |-> (s.count > limit) && $past(cond);
    endproperty
    a_needs_count: assert property (p_needs_count) else $error("early expiry");
endmodule // hold_timer

// ### rtl/out_terminal.sv
/*
 * one output terminal: picks a status by function code, applies polarity.
 * assumes the code is a stable setting on core_clk.
 */
module out_terminal
    import loop_supervisor_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // function code and status
    input wire logic [7:0] code,
    input wire status_s status,
    output logic level
);
    typedef struct packed {
        logic level;
    } term_s;
    term_s s;
    term_s next_s;
    logic sig;

    always_comb begin
        next_s = s;
        case (code)
            FN_LOOP, FN_LOOP_N: sig = status.loop_active_flag;
            FN_SUSPEND, FN_SUSPEND_N: sig = status.suspend;
            default: sig = 1'b0;
        endcase
        next_s.level = (code >= FN_INVERT) ? !sig : sig;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;

    property p_inverted_suspend;
        @(posedge core_clk) disable iff (!rstn)
        (code == FN_SUSPEND_N) |=> (level == !$past(status.suspend));
    endproperty
    a_inverted_suspend: assert property (p_inverted_suspend) else $error("bad polarity");
endmodule // out_terminal

// ### rtl/process_loop_supervisor.sv
/*
 * supervisor around a motor drive's process control loop: start-up
 * handover, suspend and resume, status terminals and monitor values.
 * assumes settings and loop values come from logic on core_clk; the
 * loop-enable, preset-speed and jog inputs are pins and are synchronised.
 */
// Operation
// - terminal codes of 100 or more drive the terminal active low
// - without a loop-enable terminal, the action selection alone enables the loop
// - thermistor level not 9999 forces the panel set point
// - open-loop start-up until output reaches the switchover frequency
// - once closed loop has begun it stays closed loop
// - suspend when loop output stays below level longer than time
// - resume when deviation reaches cancel level minus 1000 percent
// - suspend: suspend on, running off, loop active stays on
// - codes 70 and 170 route suspend status to a terminal
// - codes 52, 53, 54 select display; only 52, 53 drive analog
// - deviation monitor shows 1000 for zero deviation
// - preset-speed or jog with loop-enable on stops the loop
// - loop invalid in mode 6 or stopped with power-fail stop
// - loop limits from bias and gain, plus general maximum and minimum
// - remote speed adjustment ignored while the loop is active
// - entering closed loop starts the command from 0 Hz
// - codes 47 and 147 show loop active on a terminal
module process_loop_supervisor
    import loop_supervisor_pkg::*;
#(
    parameter int SUSPEND_TICK_CYCLES = TIME_TICK_CYCLES,
    parameter int MONITOR_CYCLES = MON_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // pins
    input wire pin_s pins,
    // settings
    input wire logic loop_enable_assigned,
    input wire logic [7:0] loop_action_select,
    input wire logic [15:0] panel_set_point,
    input wire logic [15:0] thermistor_protect_level,
    input wire logic [15:0] auto_switchover_frequency,
    input wire logic [15:0] suspend_detect_time,
    input wire logic [15:0] suspend_detect_level,
    input wire logic [15:0] suspend_cancel_level,
    input wire logic [7:0] output_function_select_a,
    input wire logic [7:0] output_function_select_b,
    input wire logic [7:0] display_data_select,
    input wire logic [7:0] analog_monitor_select,
    input wire logic [3:0] operation_mode_select,
    input wire logic power_fail_stop_select,
    input wire logic [15:0] frequency_bias_setting,
    input wire logic [15:0] frequency_gain_setting,
    input wire logic [15:0] max_frequency,
    input wire logic [15:0] min_frequency,
    // drive state and loop values
    input wire logic run_command,
    input wire logic drive_stopped,
    input wire logic [15:0] output_frequency,
    input wire logic [15:0] normal_frequency,
    input wire logic [15:0] loop_frequency,
    input wire logic [15:0] terminal_set_point,
    input wire logic [15:0] measured_value,
    // status and commands
    output logic loop_active_flag,
    output logic suspend,
    output logic running,
    output logic loop_restart,
    output logic remote_adjust_enable,
    output logic [15:0] frequency_command,
    output logic terminal_a,
    output logic terminal_b,
    // monitors
    output logic [15:0] display_value,
    output logic [15:0] analog_monitor_terminal
);
    localparam int MW = $clog2(MONITOR_CYCLES + 1);

    typedef struct packed {
        phase_e phase;
        pin_s sync1;
        pin_s sync2;
        logic loop_active;
        logic suspend;
        logic running;
        logic loop_restart;
        logic remote_ok;
        logic [15:0] freq;
        logic [MW-1:0] mon_cnt;
        logic [15:0] display;
        logic [15:0] analog;
    } state_s;

    state_s s;
    state_s next_s;
    status_s status;
    logic sleep_cond;
    logic sleep_go;
    logic selected;
    logic overridden;
    logic invalid;
    logic allowed;
    logic switch_valid;
    logic resume;
    logic mon_tick;
    logic [15:0] sp;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] clamped;
    logic [15:0] dev_enc;
    logic [17:0] dev;
    logic [17:0] dev_shift;
    logic [17:0] cancel_thr;

    // ------------------------------------------------------------
    // loop selection and overrides
    // ------------------------------------------------------------
    always_comb begin
        selected = (loop_action_select == ACT_REVERSE ||
                    loop_action_select == ACT_FORWARD) &&
                   (!loop_enable_assigned || s.sync2.loop_enable_input);
        overridden = s.sync2.loop_enable_input &&
                     (s.sync2.preset_speed_high || s.sync2.preset_speed_mid ||
                      s.sync2.preset_speed_low || s.sync2.preset_speed_extra ||
                      s.sync2.jog);
        invalid = (operation_mode_select == MODE_SWITCHOVER) ||
                  (drive_stopped && power_fail_stop_select);
        allowed = selected && !overridden && !invalid && run_command;
        switch_valid = (auto_switchover_frequency <= SWITCH_MAX);
    end

    // ------------------------------------------------------------
    // set point, deviation and limits
    // ------------------------------------------------------------
    always_comb begin
        if (panel_set_point != SETTING_OFF ||
            thermistor_protect_level != SETTING_OFF) begin
            sp = (panel_set_point == SETTING_OFF) ? VALUE_RESET : panel_set_point;
        end else begin
            sp = terminal_set_point;
        end
        dev = {2'b00, sp} - {2'b00, measured_value};
        dev_shift = dev + DEV_ZERO;
        dev_enc = dev_shift[17] ? VALUE_RESET : dev_shift[15:0];
        cancel_thr = {2'b00, suspend_cancel_level} - CANCEL_ZERO;
        resume = ($signed(dev) >= $signed(cancel_thr));
        lo = (frequency_bias_setting > min_frequency) ?
             frequency_bias_setting : min_frequency;
        hi = (frequency_gain_setting < max_frequency) ?
             frequency_gain_setting : max_frequency;
        if (loop_frequency > hi) begin
            clamped = hi;
        end else if (loop_frequency < lo) begin
            clamped = lo;
        end else begin
            clamped = loop_frequency;
        end
    end

    // ------------------------------------------------------------
    // suspend detection
    // ------------------------------------------------------------
    assign sleep_cond = (s.phase == PH_LOOP) &&
                        (suspend_detect_time != SETTING_OFF) &&
                        (loop_frequency < suspend_detect_level);

    hold_timer #(
        .TICK_CYCLES(SUSPEND_TICK_CYCLES)
    ) u_suspend_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .cond(sleep_cond),
        .limit(suspend_detect_time),
        .expired(sleep_go)
    );

    // ------------------------------------------------------------
    // phase sequence and outputs
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.loop_restart = 1'b0;
        mon_tick = (s.mon_cnt == MW'(MONITOR_CYCLES - 1));
        next_s.mon_cnt = mon_tick ? '0 : s.mon_cnt + 1'b1;
        case (s.phase)
            PH_IDLE: begin
                if (allowed) begin
                    if (switch_valid && output_frequency < auto_switchover_frequency) begin
                        next_s.phase = PH_OPEN;
                    end else begin
                        next_s.phase = PH_LOOP;
                        next_s.loop_restart = 1'b1;
                    end
                end
            end
            PH_OPEN: begin
                if (!allowed) begin
                    next_s.phase = PH_IDLE;
                end else if (output_frequency >= auto_switchover_frequency) begin
                    next_s.phase = PH_LOOP;
                    next_s.loop_restart = 1'b1;
                end
            end
            PH_LOOP: begin
                if (!allowed) begin
                    next_s.phase = PH_IDLE;
                end else if (sleep_go) begin
                    next_s.phase = PH_SLEEP;
                end
            end
            PH_SLEEP: begin
                if (!allowed) begin
                    next_s.phase = PH_IDLE;
                end else if (resume) begin
                    next_s.phase = PH_LOOP;
                end
            end
            default: next_s.phase = PH_IDLE;
        endcase
        next_s.loop_active = (next_s.phase == PH_LOOP) ||
                             (next_s.phase == PH_SLEEP);
        next_s.suspend = (next_s.phase == PH_SLEEP);
        next_s.running = run_command && (next_s.phase != PH_SLEEP);
        next_s.remote_ok = !next_s.loop_active;
        if (next_s.phase == PH_LOOP) begin
            next_s.freq = next_s.loop_restart ? VALUE_RESET : clamped;
        end else if (next_s.phase == PH_SLEEP) begin
            next_s.freq = VALUE_RESET;
        end else begin
            next_s.freq = normal_frequency;
        end
        if (mon_tick) begin
            case (display_data_select)
                MON_SET_POINT: next_s.display = sp;
                MON_MEASURED: next_s.display = measured_value;
                MON_DEVIATION: next_s.display = dev_enc;
                default: next_s.display = VALUE_RESET;
            endcase
            case (analog_monitor_select)
                MON_SET_POINT: next_s.analog = sp;
                MON_MEASURED: next_s.analog = measured_value;
                default: next_s.analog = VALUE_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.phase <= PH_IDLE;
            s.remote_ok <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // status terminals
    // ------------------------------------------------------------
    assign status.loop_active_flag = s.loop_active;
    assign status.suspend = s.suspend;

    out_terminal u_term_a (
        .core_clk(core_clk),
        .rstn(rstn),
        .code(output_function_select_a),
        .status(status),
        .level(terminal_a)
    );

    out_terminal u_term_b (
        .core_clk(core_clk),
        .rstn(rstn),
        .code(output_function_select_b),
        .status(status),
        .level(terminal_b)
    );

    assign loop_active_flag = s.loop_active;
    assign suspend = s.suspend;
    assign running = s.running;
    assign loop_restart = s.loop_restart;
    assign remote_adjust_enable = s.remote_ok;
    assign frequency_command = s.freq;
    assign display_value = s.display;
    assign analog_monitor_terminal = s.analog;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_enter;
        (s.phase == PH_IDLE || s.phase == PH_OPEN) ##1 (s.phase == PH_LOOP);
    endsequence

    property p_sleep_status;
        @(posedge core_clk) disable iff (!rstn)
        suspend |-> loop_active_flag && !running;
    endproperty
    a_sleep_status: assert property (p_sleep_status) else $error("bad suspend status");

    property p_stay_loop;
        @(posedge core_clk) disable iff (!rstn)
        (s.phase == PH_LOOP) && allowed && !sleep_go |=> (s.phase == PH_LOOP);
    endproperty
    a_stay_loop: assert property (p_stay_loop) else $error("left closed loop");

    property p_zero_start;
        @(posedge core_clk) disable iff (!rstn)
        s_enter |-> loop_restart && (frequency_command == VALUE_RESET);
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("no zero baseline");

    property p_remote_off;
        @(posedge core_clk) disable iff (!rstn)
        loop_active_flag |-> !remote_adjust_enable;
    endproperty
    a_remote_off: assert property (p_remote_off) else $error("remote active in loop");

    property p_invalid;
        @(posedge core_clk) disable iff (!rstn)
        invalid |=> !loop_active_flag;
    endproperty
    a_invalid: assert property (p_invalid) else $error("loop active while invalid");

    property p_handover;
        @(posedge core_clk) disable iff (!rstn)
        (s.phase == PH_OPEN) && allowed && (output_frequency >= auto_switchover_frequency)
        |=> loop_active_flag ##1 loop_active_flag || !$past(allowed);
    endproperty
    a_handover: assert property (p_handover) else $error("no handover");

    property p_resume;
        @(posedge core_clk) disable iff (!rstn)
        suspend && allowed && resume |=> !suspend && loop_active_flag;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");

    property p_dev_monitor;
        @(posedge core_clk) disable iff (!rstn)
        mon_tick && (display_data_select == MON_DEVIATION)
        |=> display_value == $past(dev_enc);
    endproperty
    a_dev_monitor: assert property (p_dev_monitor) else $error("bad deviation monitor");

    property p_limits;
        @(posedge core_clk) disable iff (!rstn)
        (s.phase == PH_LOOP) && allowed && !sleep_go && !loop_restart
        |=> frequency_command == $past(clamped);
    endproperty
    a_limits: assert property (p_limits) else $error("command not limited");
endmodule // process_loop_supervisor

// ### tb/loop_partner.sv
/*
 * partner model: motor frequency stage and process detector.
 * assumes the bench sets the loop output and detector levels.
 */
module loop_partner
    import loop_supervisor_pkg::*;
#(
    parameter int STEP = 50
) (
    // clock
    input wire logic core_clk,
    // command and bench levels
    input wire logic [15:0] frequency_command,
    input wire logic [15:0] loop_level,
    input wire logic [15:0] detector_level,
    // feedback
    output logic [15:0] output_frequency,
    output logic [15:0] loop_frequency,
    output logic [15:0] measured_value
);
    timeunit 1ns;
    timeprecision 1ps;
    initial output_frequency = 16'h0000;
    // motor slews toward the command
    always @(posedge core_clk) begin
        if (int'(output_frequency) + STEP < int'(frequency_command))
            output_frequency <= output_frequency + 16'(STEP);
        else if (int'(output_frequency) > int'(frequency_command) + STEP)
            output_frequency <= output_frequency - 16'(STEP);
        else
            output_frequency <= frequency_command;
    end
    assign loop_frequency = loop_level;
    assign measured_value = detector_level;
endmodule // loop_partner

// ### tb/process_loop_supervisor_tb.sv
/*
 * self-checking bench for the process loop supervisor.
 * assumes short tick and monitor periods of 4 cycles.
 */
module process_loop_supervisor_tb;
    import loop_supervisor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] term; logic lvl; logic [7:0] dsel; logic [7:0] asel;
        logic [15:0] disp; logic [15:0] am;
    } row_s;
    logic core_clk, rstn, loop_enable_assigned, power_fail_stop_select, run_command, drive_stopped;
    pin_s pins;
    logic [7:0] loop_action_select, output_function_select_a, output_function_select_b;
    logic [7:0] display_data_select, analog_monitor_select;
    logic [3:0] operation_mode_select;
    logic [15:0] panel_set_point, thermistor_protect_level, auto_switchover_frequency;
    logic [15:0] suspend_detect_time, suspend_detect_level, suspend_cancel_level;
    logic [15:0] frequency_bias_setting, frequency_gain_setting, max_frequency, min_frequency;
    logic [15:0] output_frequency, normal_frequency, loop_frequency, terminal_set_point;
    logic [15:0] measured_value, loop_level, detector_level, frequency_command;
    logic [15:0] display_value, analog_monitor_terminal;
    logic loop_active_flag, suspend, running, loop_restart, remote_adjust_enable;
    logic terminal_a, terminal_b;
    int fail_count = 0;
    int n_tests = 0;
    row_s rows [6] = '{
        '{8'h2f, 1'b1, 8'h34, 8'h35, 16'h012c, 16'h00c8},
        '{8'h93, 1'b0, 8'h35, 8'h34, 16'h00c8, 16'h012c},
        '{8'h46, 1'b0, 8'h36, 8'h36, 16'h044c, 16'h0000},
        '{8'haa, 1'b1, 8'h00, 8'h00, 16'h0000, 16'h0000},
        '{8'h64, 1'b1, 8'h34, 8'h35, 16'h012c, 16'h00c8},
        '{8'h05, 1'b0, 8'h34, 8'h35, 16'h012c, 16'h00c8}};
    // every port has a bench signal of the same name
    process_loop_supervisor #(.SUSPEND_TICK_CYCLES(4), .MONITOR_CYCLES(4)) u_process_loop_supervisor (
        .*);
    loop_partner u_loop_partner (
        .core_clk(core_clk), .frequency_command(frequency_command), .loop_level(loop_level),
        .detector_level(detector_level), .output_frequency(output_frequency),
        .loop_frequency(loop_frequency), .measured_value(measured_value));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic clamp_case(input logic [15:0] lv, b, mx, mn, exp);
        loop_level = lv; frequency_bias_setting = b; max_frequency = mx; min_frequency = mn;
        cyc(3);
        chk(frequency_command, exp);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #50000;
        fail_count++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // settings loaded while stopped
        rstn = 1'b0; pins = '0; loop_enable_assigned = 1'b0; loop_action_select = ACT_REVERSE;
        panel_set_point = SETTING_OFF; thermistor_protect_level = SETTING_OFF;
        auto_switchover_frequency = SETTING_OFF; suspend_detect_time = SETTING_OFF;
        suspend_detect_level = 16'h012c; suspend_cancel_level = 16'h2774;
        output_function_select_a = 8'h00; output_function_select_b = FN_LOOP_N;
        display_data_select = 8'h00; analog_monitor_select = 8'h00;
        operation_mode_select = 4'h0; power_fail_stop_select = 1'b0; drive_stopped = 1'b0;
        frequency_bias_setting = 16'h0000; frequency_gain_setting = 16'h0fa0;
        max_frequency = 16'h0fa0; min_frequency = 16'h0000; run_command = 1'b0;
        normal_frequency = 16'h07d0; terminal_set_point = 16'h012c;
        loop_level = 16'h07d0; detector_level = 16'h00c8;
        cyc(20);
        chk({loop_active_flag, suspend, running, loop_restart, remote_adjust_enable}, 16'h0001);
        chk(frequency_command, 16'h0000);
        rstn = 1'b1;
        cyc(2);
        run_command = 1'b1;
        @(posedge core_clk); #1;
        chk({loop_active_flag, loop_restart, remote_adjust_enable}, 16'h0006);
        chk(frequency_command, 16'h0000);
        @(posedge core_clk); #1;
        chk({loop_restart, frequency_command[14:0]}, 16'h07d0);
        foreach (rows[i]) begin
            cyc(1);
            output_function_select_a = rows[i].term;
            display_data_select = rows[i].dsel; analog_monitor_select = rows[i].asel;
            cyc(12);
            chk(terminal_a, rows[i].lvl);
            chk(display_value, rows[i].disp);
            chk(analog_monitor_terminal, rows[i].am);
        end
        chk(terminal_b, 1'b0);
        thermistor_protect_level = 16'h0064; panel_set_point = 16'h01f4;
        cyc(12);
        chk(display_value, 16'h01f4);
        thermistor_protect_level = SETTING_OFF; panel_set_point = SETTING_OFF;
        clamp_case(16'h1388, 16'h0000, 16'h0fa0, 16'h0000, 16'h0fa0);
        clamp_case(16'h1388, 16'h0000, 16'h0bb8, 16'h0000, 16'h0bb8);
        clamp_case(16'h00c8, 16'h03e8, 16'h0fa0, 16'h0000, 16'h03e8);
        clamp_case(16'h00c8, 16'h03e8, 16'h0fa0, 16'h05dc, 16'h05dc);
        frequency_bias_setting = 16'h0000; min_frequency = 16'h0000;
        output_function_select_a = FN_SUSPEND; suspend_detect_time = 16'h0002;
        detector_level = 16'h00fa;
        repeat (8) begin
            loop_level = 16'h0064; cyc(6);
            loop_level = 16'h0190; cyc(1);
        end
        chk(suspend, 1'b0);
        loop_level = 16'h0064;
        cyc(7);
        chk(suspend, 1'b0);
        for (int i = 0; i < 40 && suspend !== 1'b1; i++) cyc(1);
        cyc(2);
        chk({suspend, running, loop_active_flag, terminal_a}, 16'h000b);
        chk(frequency_command, 16'h0000);
        cyc(5);
        chk(suspend, 1'b1);
        detector_level = 16'h0096;
        cyc(2);
        chk({suspend, loop_active_flag}, 16'h0001);
        suspend_detect_time = SETTING_OFF; run_command = 1'b0;
        cyc(3);
        auto_switchover_frequency = 16'h03e8; run_command = 1'b1;
        cyc(3);
        chk(loop_active_flag, 1'b0);
        for (int i = 0; i < 60 && loop_active_flag !== 1'b1; i++) cyc(1);
        chk({loop_active_flag, 15'(output_frequency >= 16'h03e8)}, 16'h8001);
        cyc(40);
        chk({loop_active_flag, 15'(output_frequency <= 16'h03e8)}, 16'h8001);
        auto_switchover_frequency = SETTING_OFF;
        for (int i = 0; i < 5; i++) begin
            pins = pin_s'(6'h20 | (6'h01 << i));
            cyc(5);
            chk(loop_active_flag, 1'b0);
            pins = pin_s'(6'h20);
            cyc(5);
            chk(loop_active_flag, 1'b1);
        end
        operation_mode_select = MODE_SWITCHOVER;
        cyc(3);
        chk(loop_active_flag, 1'b0);
        operation_mode_select = 4'h0;
        cyc(3);
        chk(loop_active_flag, 1'b1);
        power_fail_stop_select = 1'b1; drive_stopped = 1'b1;
        cyc(3);
        chk(loop_active_flag, 1'b0);
        power_fail_stop_select = 1'b0; loop_enable_assigned = 1'b1; pins = '0;
        cyc(5);
        chk(loop_active_flag, 1'b0);
        pins = pin_s'(6'h20);
        cyc(5);
        chk(loop_active_flag, 1'b1);
        report_and_stop();
    end
endmodule // process_loop_supervisor_tb
